// ### core/mhp_pkg.sv
// constants shared by the muxed host port
`default_nettype none
package mhp_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int HOST_W = 16;
  // pin positions of the top address bit per width and latching mode
  localparam int TOP_PIN_8_SINGLE = 9;
  localparam int TOP_PIN_8_DUAL = 1;
  localparam int TOP_PIN_16_SINGLE = 8;
  localparam int TOP_PIN_16_DUAL = 0;
  localparam int ENDIAN_OFS = 1;
  localparam int FIFOSEL_OFS = 2;
  localparam logic [2:0] PARTS_8 = 3'h4;
  localparam logic [2:0] PARTS_16 = 3'h2;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [HOST_W-1:0] HOST_RST = 16'h0000;
  typedef enum logic [1:0] {
    MHP_IDLE = 2'b00,
    MHP_WRITE = 2'b01,
    MHP_READ = 2'b11
  } mhp_state_e;
endpackage : mhp_pkg
`default_nettype wire

// ### core/mhp_snap.sv
// snapshot register holding the live word during a read sequence
`default_nettype none
module mhp_snap
  import mhp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout <= WORD_RST;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule : mhp_snap
`default_nettype wire

// ### core/mhp_port.sv
// muxed host bus port: address decode, dword assembly and read split
// Operation
// - 8-bit mode: byte address, top bit on pin 9 single or 1 dual
// - 16-bit mode: word address, top bit on pin 8 single or 0 dual
// - latched address converted to byte address before internal use
// - endianness select sits one pin above the top address bit
// - fifo direct select sits two pins above the top address bit
// - registers are 32 bits; narrow modes need two or four accesses
// - write cycle: select plus write strobe, or gate with write direction
// - at write end the part is stored in its lane, endian swapped
// - after initialisation writes are dropped until one read occurs
// - outside full power and after it, writes dropped until a read
// - write counter counts parts; last part issues one 32-bit write
// - write counter cleared when power state leaves full power
// - read cycle decode; part driven from the cycle start, old snapshot lane in the first clock of an unlocked register read
// - reads ignored outside full power, including a read's tail
// - separate read counter; last part issues one internal read
// - read counter cleared when power state leaves full power
// - live bits frozen at the start of a read cycle
// - multi-part registers locked first read to last, unlocked on power
// - pops and change-on-read act at read end, after the last part
// - endian select low is little endian, high is big endian
// - fifo select sends writes to tx fifo and reads from rx fifo
// - address and selects kept until reset or a new latch
// - events during a hold or lock are deferred, not lost
`default_nettype none
module mhp_port
  import mhp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic mode_8bit,
  input wire logic dual_phase,
  input wire logic enable_mode,
  input wire logic cs_act,
  input wire logic rd_act,
  input wire logic wr_act,
  input wire logic bus_cycle_gate,
  input wire logic dir_is_read,
  input wire logic low_latch_strobe,
  input wire logic high_latch_strobe,
  input wire logic [HOST_W-1:0] ad_in,
  output logic [HOST_W-1:0] ad_out,
  output logic ad_oe,
  input wire logic full_power_state,
  input wire logic init_done,
  output logic [ADDR_W-1:0] int_addr,
  output logic int_fifo_sel,
  output logic int_big_endian,
  output logic [DATA_W-1:0] int_wdata,
  output logic int_wr,
  output logic int_txfifo_wr,
  input wire logic [DATA_W-1:0] int_rdata,
  input wire logic [DATA_W-1:0] rxfifo_rdata,
  output logic int_rd_end,
  output logic int_rxfifo_pop,
  output logic int_lock,
  output logic int_hold
);
  // latched address fields
  logic [ADDR_W-1:0] addr_q;
  logic endian_q;
  logic fifo_q;
  logic lo_q;
  logic hi_q;
  mhp_state_e st_q;
  logic [2:0] wcnt_q;
  logic [2:0] rcnt_q;
  logic wr_armed_q;
  logic init_q;
  logic lock_q;
  logic [DATA_W-1:0] asm_q;
  logic [DATA_W-1:0] snap;
  logic [HOST_W-1:0] rd_q;
  logic rd_valid_q;
  logic pwr_q;

  function automatic logic [7:0] lane(input logic [DATA_W-1:0] w,
                                      input logic [1:0] idx);
    lane = w[8*idx +: 8];
  endfunction : lane

  wire [2:0] parts = mode_8bit ? PARTS_8 : PARTS_16;
  wire wr_cyc = enable_mode ? (bus_cycle_gate && !dir_is_read)
                            : (cs_act && wr_act);
  wire rd_cyc = enable_mode ? (bus_cycle_gate && dir_is_read)
                            : (cs_act && rd_act);
  wire lo_fall = lo_q && !low_latch_strobe;
  wire hi_fall = hi_q && !high_latch_strobe;
  wire pwr_leave = pwr_q && !full_power_state;

  // top address pin position for the active width and latching mode
  wire [3:0] top_pin = mode_8bit
    ? (dual_phase ? 4'(TOP_PIN_8_DUAL) : 4'(TOP_PIN_8_SINGLE))
    : (dual_phase ? 4'(TOP_PIN_16_DUAL) : 4'(TOP_PIN_16_SINGLE));
  wire endian_pin = ad_in[4'(top_pin + 4'(ENDIAN_OFS))];
  wire fifo_pin = ad_in[4'(top_pin + 4'(FIFOSEL_OFS))];

  // single phase: whole address on the low strobe
  wire [ADDR_W-1:0] single_addr = mode_8bit ? ad_in[9:0]
                                            : {ad_in[8:0], 1'b0};
  // dual phase: low strobe gives 8 bits, high strobe the rest
  wire [ADDR_W-1:0] dual_lo = mode_8bit ? {addr_q[9:8], ad_in[7:0]}
                                        : {addr_q[9], ad_in[7:0], 1'b0};
  wire [ADDR_W-1:0] dual_hi = mode_8bit ? {ad_in[1:0], addr_q[7:0]}
                                        : {ad_in[0], addr_q[8:0]};

  // lane selection per endianness
  wire [1:0] byte_idx = addr_q[1:0] ^ {endian_q, endian_q};
  wire word_idx = addr_q[1] ^ endian_q;
  wire [DATA_W-1:0] src = fifo_q ? rxfifo_rdata : snap;
  wire [HOST_W-1:0] rd_sel = mode_8bit
    ? {8'h00, lane(src, byte_idx)}
    : (endian_q ? {lane(src, {word_idx, 1'b0}),
                   lane(src, {word_idx, 1'b1})}
                : {lane(src, {word_idx, 1'b1}),
                   lane(src, {word_idx, 1'b0})});
  wire [HOST_W-1:0] wr_part = (!mode_8bit && endian_q)
    ? {ad_in[7:0], ad_in[15:8]} : ad_in;

  wire wr_end = (st_q == MHP_WRITE) && !wr_cyc;
  wire rd_end = (st_q == MHP_READ) && !rd_cyc;
  wire wr_take = wr_end && wr_armed_q && init_q && full_power_state;
  wire rd_take = rd_end && rd_valid_q && full_power_state;
  wire wr_last = wr_take && (3'(wcnt_q + 3'h1) == parts);
  wire rd_last = rd_take && (3'(rcnt_q + 3'h1) == parts);
  wire rd_start = (st_q == MHP_IDLE) && rd_cyc && full_power_state;
  wire snap_load = rd_start && !lock_q;

  mhp_snap u_snap (
    .clk(clk),
    .nrst(nrst),
    .load(snap_load),
    .din(int_rdata),
    .dout(snap)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_q <= 1'b0;
      hi_q <= 1'b0;
      pwr_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      lo_q <= low_latch_strobe;
      hi_q <= high_latch_strobe;
      pwr_q <= full_power_state;
      init_q <= init_done;
    end
  end

  // address latch on trailing strobe edges, kept otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= ADDR_RST;
      endian_q <= 1'b0;
      fifo_q <= 1'b0;
    end else if (!dual_phase && lo_fall) begin
      addr_q <= single_addr;
      endian_q <= endian_pin;
      fifo_q <= fifo_pin;
    end else if (dual_phase && lo_fall) begin
      addr_q <= dual_lo;
    end else if (dual_phase && hi_fall) begin
      addr_q <= dual_hi;
      endian_q <= endian_pin;
      fifo_q <= fifo_pin;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= MHP_IDLE;
    end else begin
      case (st_q)
        MHP_IDLE: begin
          if (wr_cyc) begin
            st_q <= MHP_WRITE;
          end else if (rd_cyc) begin
            st_q <= MHP_READ;
          end
        end
        MHP_WRITE: begin
          if (!wr_cyc) begin
            st_q <= MHP_IDLE;
          end
        end
        MHP_READ: begin
          if (!rd_cyc) begin
            st_q <= MHP_IDLE;
          end
        end
        default: st_q <= MHP_IDLE;
      endcase
    end
  end

  // a write is only honoured once a read has been seen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_armed_q <= 1'b0;
    end else if (!full_power_state || !init_q) begin
      wr_armed_q <= 1'b0;
    end else if (rd_take) begin
      wr_armed_q <= 1'b1;
    end
  end

  // read valid only if the whole cycle ran in full power
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
    end else if (rd_start) begin
      rd_valid_q <= 1'b1;
    end else if (!full_power_state || st_q != MHP_READ) begin
      rd_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wcnt_q <= CNT_RST;
    end else if (pwr_leave || !full_power_state) begin
      wcnt_q <= CNT_RST;
    end else if (wr_last) begin
      wcnt_q <= CNT_RST;
    end else if (wr_take) begin
      wcnt_q <= 3'(wcnt_q + 3'h1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= CNT_RST;
    end else if (!full_power_state) begin
      rcnt_q <= CNT_RST;
    end else if (rd_last) begin
      rcnt_q <= CNT_RST;
    end else if (rd_take) begin
      rcnt_q <= 3'(rcnt_q + 3'h1);
    end
  end

  // lock spans first to last part of a narrow read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 1'b0;
    end else if (!full_power_state || rd_last) begin
      lock_q <= 1'b0;
    end else if (rd_take) begin
      lock_q <= 1'b1;
    end
  end

  // dword assembly, lane picked by low address and endianness
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asm_q <= WORD_RST;
    end else if (wr_take && mode_8bit) begin
      asm_q[8*byte_idx +: 8] <= wr_part[7:0];
    end else if (wr_take) begin
      asm_q[16*word_idx +: 16] <= wr_part;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= HOST_RST;
    end else if (st_q == MHP_READ || rd_start) begin
      rd_q <= rd_sel;
    end
  end

  // internal write carries the full dword including the final part
  wire [DATA_W-1:0] wr_word = mode_8bit
    ? (asm_q & ~(32'h0000_00FF << {byte_idx, 3'h0}))
      | ({24'h00_0000, wr_part[7:0]} << {byte_idx, 3'h0})
    : (word_idx ? {wr_part, asm_q[15:0]} : {asm_q[31:16], wr_part});

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_wdata <= WORD_RST;
      int_wr <= 1'b0;
      int_txfifo_wr <= 1'b0;
      int_rd_end <= 1'b0;
      int_rxfifo_pop <= 1'b0;
    end else begin
      int_wdata <= wr_last ? wr_word : int_wdata;
      int_wr <= wr_last && !fifo_q;
      int_txfifo_wr <= wr_last && fifo_q;
      int_rd_end <= rd_last && !fifo_q;
      int_rxfifo_pop <= rd_last && fifo_q;
    end
  end

  // dword-aligned byte address toward the register file
  assign int_addr = {addr_q[9:2], 2'b00};
  assign int_fifo_sel = fifo_q;
  assign int_big_endian = endian_q;
  assign int_lock = lock_q;
  // holders defer their events while this is high
  assign int_hold = lock_q || st_q == MHP_READ;
  assign ad_out = rd_q;
  assign ad_oe = (st_q == MHP_READ) && rd_valid_q;
endmodule : mhp_port
`default_nettype wire

// ### sim/mhp_port_asserts.sv
// concurrent checks on the muxed host port boundary
`default_nettype none
module mhp_port_asserts
  import mhp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable_mode,
  input wire logic cs_act,
  input wire logic rd_act,
  input wire logic wr_act,
  input wire logic bus_cycle_gate,
  input wire logic dir_is_read,
  input wire logic low_latch_strobe,
  input wire logic high_latch_strobe,
  input wire logic full_power_state,
  input wire logic ad_oe,
  input wire logic [ADDR_W-1:0] int_addr,
  input wire logic int_fifo_sel,
  input wire logic int_big_endian,
  input wire logic int_wr,
  input wire logic int_txfifo_wr,
  input wire logic int_rd_end,
  input wire logic int_lock
);
  wire logic wcyc = enable_mode ? bus_cycle_gate & ~dir_is_read
                                : cs_act & wr_act;
  wire logic rcyc = enable_mode ? bus_cycle_gate & dir_is_read
                                : cs_act & rd_act;
  wire logic any_ale = low_latch_strobe | high_latch_strobe;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_start;
    $rose(rcyc) && full_power_state ##1 rcyc && full_power_state;
  endsequence
  sequence s_low_pwr;
    !full_power_state ##1 !full_power_state;
  endsequence
  AST_WR_END: assert property (
    int_wr |-> $past(wcyc, 2) && !$past(wcyc))
    else $error("internal write without a finished write cycle");
  AST_RD_END: assert property (
    int_rd_end |-> $past(rcyc, 2) && !$past(rcyc))
    else $error("read end without a finished read cycle");
  AST_OE_START: assert property (
    s_rd_start |=> ad_oe)
    else $error("read data not driven after read start");
  AST_OE_SRC: assert property (
    ad_oe |-> $past(rcyc))
    else $error("pins driven outside a read cycle");
  AST_LOW_PWR_RD: assert property (
    s_low_pwr |-> !ad_oe && !int_rd_end && !int_lock)
    else $error("read activity or lock outside full power");
  AST_LOW_PWR_WR: assert property (
    !full_power_state |=> !int_wr && !int_txfifo_wr)
    else $error("write issued outside full power");
  AST_ADDR_HELD: assert property (
    $changed(int_addr) || $changed(int_big_endian) || $changed(int_fifo_sel)
    |-> $past(any_ale) || $past(any_ale, 2) || $past(any_ale, 3))
    else $error("latched address changed without a latch cycle");
  AST_ALIGN: assert property (
    int_addr[1:0] == 2'b00)
    else $error("internal address not dword aligned");
  AST_ROUTE: assert property (
    int_wr |-> !int_fifo_sel)
    else $error("register write while fifo select is set");
endmodule : mhp_port_asserts
bind mhp_port mhp_port_asserts mhp_port_asserts_i (
  .clk(clk), .nrst(nrst), .enable_mode(enable_mode), .cs_act(cs_act),
  .rd_act(rd_act), .wr_act(wr_act), .bus_cycle_gate(bus_cycle_gate),
  .dir_is_read(dir_is_read), .low_latch_strobe(low_latch_strobe),
  .high_latch_strobe(high_latch_strobe), .ad_oe(ad_oe),
  .full_power_state(full_power_state), .int_addr(int_addr),
  .int_fifo_sel(int_fifo_sel), .int_big_endian(int_big_endian),
  .int_wr(int_wr), .int_txfifo_wr(int_txfifo_wr),
  .int_rd_end(int_rd_end), .int_lock(int_lock)
);
`default_nettype wire

// ### sim/mhp_host_mdl.sv
// host processor model driving the shared pins and strobes
`default_nettype none
module mhp_host_mdl
  import mhp_pkg::*;
(
  input wire logic clk,
  input wire logic enable_mode,
  input wire logic ad_oe,
  input wire logic [HOST_W-1:0] ad_out,
  output logic [HOST_W-1:0] ad_host,
  output logic low_latch_strobe,
  output logic cs_act,
  output logic rd_act,
  output logic wr_act,
  output logic bus_cycle_gate,
  output logic dir_is_read
);
  initial begin
    ad_host = HOST_RST;
    {low_latch_strobe, cs_act, rd_act, wr_act} = 4'h0;
    {bus_cycle_gate, dir_is_read} = 2'h0;
  end
  // one latch phase carries address, endian and fifo select
  task latch(input logic [HOST_W-1:0] v);
    @(negedge clk);
    ad_host = v;
    low_latch_strobe = 1'b1;
    @(negedge clk);
    low_latch_strobe = 1'b0;
    @(negedge clk);
    ad_host = ~v;
  endtask : latch
  // caller keeps parts of a dword distinct and in one dword
  task xfer(input logic wr, input logic [HOST_W-1:0] d,
            output logic [HOST_W-1:0] q, output logic oe);
    @(negedge clk);
    if (wr) ad_host = d;
    if (enable_mode) begin
      bus_cycle_gate = 1'b1;
      dir_is_read = !wr;
    end else begin
      cs_act = 1'b1;
      wr_act = wr;
      rd_act = !wr;
    end
    repeat (2) @(negedge clk);
    q = ad_out;
    oe = ad_oe;
    @(negedge clk);
    {cs_act, rd_act, wr_act, bus_cycle_gate} = 4'h0;
    // data held past the end edge, where the part is captured
    @(negedge clk);
    ad_host = ~ad_host;
    @(negedge clk);
  endtask : xfer
endmodule : mhp_host_mdl
`default_nettype wire

// ### sim/test_muxed_host_bus_dword_port.sv
// self-checking bench for the muxed host port
`default_nettype none
module test_muxed_host_bus_dword_port
  import mhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, enable_mode, full_power_state, init_done, e, f, o;
  logic cs_act, rd_act, wr_act, bus_cycle_gate, dir_is_read, low_latch_strobe;
  logic ad_oe, oe, int_fifo_sel, int_big_endian, int_wr, int_txfifo_wr;
  logic int_rd_end, int_rxfifo_pop;
  logic [HOST_W-1:0] ad_host, ad_out, q;
  logic [ADDR_W-1:0] int_addr;
  logic [DATA_W-1:0] int_wdata, d, wseen;
  logic [7:0] a;
  integer seed = 32'h4b2d0f2f;
  int n_fail = 0, checked = 0, n_wr = 0, n_rd = 0, k0;
  wire logic [HOST_W-1:0] ad_wire = ad_oe ? ad_out : ad_host;
  mhp_port mhp_port_i (.clk(clk), .nrst(nrst), .mode_8bit(1'b0),
    .dual_phase(1'b0), .enable_mode(enable_mode), .cs_act(cs_act),
    .rd_act(rd_act), .wr_act(wr_act), .bus_cycle_gate(bus_cycle_gate),
    .dir_is_read(dir_is_read), .low_latch_strobe(low_latch_strobe),
    .high_latch_strobe(1'b0), .ad_in(ad_wire), .ad_out(ad_out),
    .ad_oe(ad_oe), .full_power_state(full_power_state),
    .init_done(init_done), .int_addr(int_addr), .int_fifo_sel(int_fifo_sel),
    .int_big_endian(int_big_endian), .int_wdata(int_wdata), .int_wr(int_wr),
    .int_txfifo_wr(int_txfifo_wr), .int_rdata(d), .rxfifo_rdata(~d),
    .int_rd_end(int_rd_end), .int_rxfifo_pop(int_rxfifo_pop), .int_lock(),
    .int_hold());
  mhp_host_mdl mhp_host_mdl_i (.clk(clk), .enable_mode(enable_mode),
    .ad_oe(ad_oe), .ad_out(ad_out), .ad_host(ad_host),
    .low_latch_strobe(low_latch_strobe), .cs_act(cs_act), .rd_act(rd_act),
    .wr_act(wr_act), .bus_cycle_gate(bus_cycle_gate),
    .dir_is_read(dir_is_read));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (int_wr || int_txfifo_wr) begin
      n_wr <= n_wr + 1;
      wseen <= int_wdata;
    end
    // fifo reads end in a pop rather than a register read
    if (int_rd_end || int_rxfifo_pop) n_rd <= n_rd + 1;
  end
  function automatic logic [15:0] part(logic [31:0] v, logic i, logic be);
    logic [15:0] w;
    w = v[16 * (i ^ be) +: 16];
    return be ? {w[7:0], w[15:8]} : w;
  endfunction : part
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task acc(input logic wr, input logic idx);
    mhp_host_mdl_i.latch({5'h00, f, e, a, idx});
    mhp_host_mdl_i.xfer(wr, part(d, idx, e), q, oe);
  endtask : acc
  task pair(input logic wr);
    int k;
    k = wr ? n_wr : n_rd;
    for (int j = 0; j < 2; j++) begin
      acc(wr, j[0] ^ o);
      chk("count", k + j, wr ? n_wr : n_rd);
      if (!wr) chk("rdata", {1'b1, part(f ? ~d : d, j[0] ^ o, e)}, {oe, q});
    end
    if (wr) chk("wdata", d, wseen);
    if (wr) chk("addr", {f, e, f ? 8'h00 : a},
                {int_fifo_sel, int_big_endian, f ? 8'h00 : int_addr[9:2]});
  endtask : pair
  task end_sim;
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    {nrst, enable_mode, init_done, e, f, o, a} = 14'h0000;
    full_power_state = 1'b1;
    d = $random(seed);
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    init_done = 1'b1;
    repeat (2) @(negedge clk);
    acc(1'b1, 1'b0);
    acc(1'b1, 1'b1);
    chk("early_wr", 0, n_wr);
    pair(1'b0);
    pair(1'b1);
    for (int i = 0; i < 8; i++) begin
      {a, e, f, o, enable_mode} = $random(seed);
      d = $random(seed);
      pair(1'b1);
      pair(1'b0);
    end
    {e, f, o} = 3'h0;
    d = $random(seed);
    acc(1'b1, 1'b0);
    acc(1'b0, 1'b0);
    full_power_state = 1'b0;
    acc(1'b0, 1'b1);
    chk("lowpwr_oe", 0, oe);
    full_power_state = 1'b1;
    k0 = n_wr;
    acc(1'b1, 1'b1);
    pair(1'b0);
    acc(1'b1, 1'b1);
    chk("wr_cleared", k0, n_wr);
    acc(1'b1, 1'b0);
    chk("wr_after", k0 + 1, n_wr);
    acc(1'b1, 1'b0);
    acc(1'b0, 1'b0);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    pair(1'b0);
    pair(1'b1);
    end_sim();
  end
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end
endmodule : test_muxed_host_bus_dword_port
`default_nettype wire
